// file: shared/tvr_regs.svh
// timing and sizing constants of the trip value recorder
`ifndef TVR_REGS_SVH
`define TVR_REGS_SVH

// clock
`define TVR_CLK_KHZ 20000
// history sample period in microseconds, and its cycle count
`define TVR_SAMPLE_US 1000
`define TVR_SAMPLE_CYCLES ((`TVR_SAMPLE_US * `TVR_CLK_KHZ) / 1000)
// capture instants in milliseconds
`define TVR_SAMPLE_MS 1
`define TVR_PREFAULT_MS 100
`define TVR_FAULT1_MS 10
`define TVR_FAULT2_MS 20
// the same instants as counts of history samples
`define TVR_PREFAULT_SMP (`TVR_PREFAULT_MS / `TVR_SAMPLE_MS)
`define TVR_FAULT1_SMP (`TVR_FAULT1_MS / `TVR_SAMPLE_MS)
`define TVR_FAULT2_SMP (`TVR_FAULT2_MS / `TVR_SAMPLE_MS)
// history ring
`define TVR_HIST_DEPTH 128
`define TVR_HIST_AW 7
// widths
`define TVR_MAG_W 16
`define TVR_PRI_W 32
`define TVR_DIV_W 24
`define TVR_MS_W 5
// event record layout: index of first fault record
`define TVR_REC_COUNT 6
`define TVR_REC_FAULT0 3

`endif

// file: shared/tvr_pkg.sv
// types of the trip value recorder
`include "tvr_regs.svh"

package tvr_pkg;

  typedef logic [`TVR_MAG_W-1:0] tvr_mag_t;
  typedef logic [`TVR_MAG_W-1:0] tvr_ratio_t;
  typedef logic [`TVR_PRI_W-1:0] tvr_pri_t;

  typedef struct packed {
    tvr_mag_t [2:0] ch;
  } tvr_mag3_t;

  typedef struct packed {
    tvr_ratio_t [2:0] ch;
  } tvr_ratio3_t;

  typedef struct packed {
    tvr_pri_t [2:0] ch;
  } tvr_pri3_t;

  typedef struct packed {
    logic isFault;
    logic [1:0] chan;
    tvr_pri_t value;
  } tvr_event_t;

  typedef enum logic [3:0] {
    TVR_IDLE = 4'h1,
    TVR_COLLECT = 4'h2,
    TVR_WAIT = 4'h4,
    TVR_REPORT = 4'h8
  } tvr_state_t;

endpackage

// file: src/tvr_recorder.sv
// trip value recorder: prefault and fault capture of three channels, event output
//
// Notes on behaviour
// - start edge captures prefault and fault values
// - new start before trip overwrites captures
// - trip activation emits value records upstream
// - prefault is magnitude 100 ms before start
// - fault is mean of 10/20 ms samples
// - secondary inputs scaled to primary values first
`include "tvr_regs.svh"

module tvr_recorder #(
  parameter int SAMPLE_CYCLES = `TVR_SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // general start and trip from protection logic
  input wire logic startIn,
  input wire logic tripIn,
  // secondary magnitudes and transformer ratios
  input wire tvr_pkg::tvr_mag3_t secMag,
  input wire tvr_pkg::tvr_ratio3_t ratio,
  // event records toward the event list
  output logic evtValid,
  output tvr_pkg::tvr_event_t evtRec,
  // waiting for trip with valid captures
  output logic armed
);
  import tvr_pkg::*;

  // ==========================================================
  // helpers
  function automatic tvr_pri_t toPrimary(input tvr_mag_t m, input tvr_ratio_t r);
    logic [2*`TVR_MAG_W-1:0] p;
    p = m * r;
    return tvr_pri_t'(p);
  endfunction

  function automatic tvr_pri_t meanOf(input tvr_pri_t a, input tvr_pri_t b);
    logic [`TVR_PRI_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[`TVR_PRI_W:1];
  endfunction

  function automatic logic divWrap(input logic [`TVR_DIV_W-1:0] c);
    return c == `TVR_DIV_W'(SAMPLE_CYCLES - 1);
  endfunction

  // ==========================================================
  // primary conversion
  tvr_pri3_t priNow_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      priNow_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        priNow_q.ch[i] <= toPrimary(secMag.ch[i], ratio.ch[i]);
      end
    end
  end

  // ==========================================================
  // free-running history sampler
  logic [`TVR_DIV_W-1:0] histDiv_q;
  logic [`TVR_HIST_AW-1:0] wrPtr_q;
  logic [`TVR_HIST_AW-1:0] fill_q;
  logic histTick;
  logic histReady;
  tvr_pri3_t hist [0:`TVR_HIST_DEPTH-1];
  tvr_pri3_t histOld;

  assign histTick = divWrap(histDiv_q);
  assign histReady = fill_q >= `TVR_HIST_AW'(`TVR_PREFAULT_SMP);
  // entry written between 99 and 100 ms ago
  assign histOld = hist[wrPtr_q - `TVR_HIST_AW'(`TVR_PREFAULT_SMP)];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      histDiv_q <= '0;
      wrPtr_q <= '0;
      fill_q <= '0;
    end else begin
      histDiv_q <= histTick ? '0 : histDiv_q + `TVR_DIV_W'(1);
      if (histTick) begin
        wrPtr_q <= wrPtr_q + `TVR_HIST_AW'(1);
        if (!histReady) begin
          fill_q <= fill_q + `TVR_HIST_AW'(1);
        end
      end
    end
  end

  // ring storage carries no reset; fill_q masks stale entries
  always_ff @(posedge sys_clk) begin
    if (histTick) begin
      hist[wrPtr_q] <= priNow_q;
    end
  end

  // ==========================================================
  // edge detection; both inputs come from logic on this clock
  logic startPrev_q;
  logic tripPrev_q;
  logic startEdge;
  logic tripEdge;

  assign startEdge = startIn & ~startPrev_q;
  assign tripEdge = tripIn & ~tripPrev_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      startPrev_q <= 1'b0;
      tripPrev_q <= 1'b0;
    end else begin
      startPrev_q <= startIn;
      tripPrev_q <= tripIn;
    end
  end

  // ==========================================================
  // control
  tvr_state_t state_q;
  logic [`TVR_DIV_W-1:0] sinceDiv_q;
  logic [`TVR_MS_W-1:0] ms_q;
  logic startPend_q;
  logic tripPend_q;
  logic [2:0] recIdx_q;
  logic sinceTick;
  logic startGo;
  logic lastSample;

  assign sinceTick = divWrap(sinceDiv_q);
  assign lastSample = sinceTick && (ms_q == `TVR_MS_W'(`TVR_FAULT2_SMP - 1));
  // a start seen while reporting is held, then served once idle
  assign startGo = (startEdge | startPend_q) && (state_q != TVR_REPORT);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TVR_IDLE;
      sinceDiv_q <= '0;
      ms_q <= '0;
      startPend_q <= 1'b0;
      tripPend_q <= 1'b0;
      recIdx_q <= '0;
    end else begin
      if (state_q == TVR_REPORT) begin
        startPend_q <= startPend_q | startEdge;
      end else begin
        startPend_q <= 1'b0;
      end
      if (startGo) begin
        state_q <= TVR_COLLECT;
        sinceDiv_q <= '0;
        ms_q <= '0;
        tripPend_q <= 1'b0;
      end else begin
        case (state_q)
          TVR_COLLECT: begin
            sinceDiv_q <= sinceTick ? '0 : sinceDiv_q + `TVR_DIV_W'(1);
            if (sinceTick) begin
              ms_q <= ms_q + `TVR_MS_W'(1);
            end
            // trip before the fault window closes waits for it
            if (tripEdge) begin
              tripPend_q <= 1'b1;
            end
            if (lastSample) begin
              state_q <= (tripPend_q | tripEdge) ? TVR_REPORT : TVR_WAIT;
              recIdx_q <= '0;
              tripPend_q <= 1'b0;
            end
          end
          TVR_WAIT: begin
            if (tripEdge) begin
              state_q <= TVR_REPORT;
              recIdx_q <= '0;
            end
          end
          TVR_REPORT: begin
            if (recIdx_q == 3'(`TVR_REC_COUNT - 1)) begin
              state_q <= TVR_IDLE;
            end
            recIdx_q <= recIdx_q + 3'(1);
          end
          default: begin
            state_q <= TVR_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // value capture
  tvr_pri3_t pre_q;
  tvr_pri3_t f10_q;
  tvr_pri3_t fault_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
      f10_q <= '0;
      fault_q <= '0;
    end else begin
      if (startGo) begin
        pre_q <= histReady ? histOld : '0;
      end else if (state_q == TVR_COLLECT && sinceTick) begin
        if (ms_q == `TVR_MS_W'(`TVR_FAULT1_SMP - 1)) begin
          f10_q <= priNow_q;
        end
        if (lastSample) begin
          for (int i = 0; i < 3; i++) begin
            fault_q.ch[i] <= meanOf(f10_q.ch[i], priNow_q.ch[i]);
          end
        end
      end
    end
  end

  // ==========================================================
  // event records, one per cycle: prefault ch0..2 then fault ch0..2
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evtValid <= 1'b0;
      evtRec <= '0;
      armed <= 1'b0;
    end else begin
      armed <= (state_q == TVR_WAIT) && !startGo && !tripEdge;
      evtValid <= (state_q == TVR_REPORT);
      if (state_q == TVR_REPORT) begin
        if (recIdx_q >= 3'(`TVR_REC_FAULT0)) begin
          evtRec.isFault <= 1'b1;
          evtRec.chan <= 2'(recIdx_q - 3'(`TVR_REC_FAULT0));
          evtRec.value <= fault_q.ch[2'(recIdx_q - 3'(`TVR_REC_FAULT0))];
        end else begin
          evtRec.isFault <= 1'b0;
          evtRec.chan <= recIdx_q[1:0];
          evtRec.value <= pre_q.ch[recIdx_q[1:0]];
        end
      end
    end
  end

endmodule

// file: verification/tvr_prot_model.sv
// protection start and trip logic model driving the recorder
module tvr_prot_model (
  // clock
  input wire logic sys_clk,
  // general start and trip
  output logic startIn,
  output logic tripIn
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    startIn = 1'b0;
    tripIn = 1'b0;
  end
  // two-cycle level pulse, edge taken on its first high sample
  task automatic pulse(input bit isTrip);
    @(posedge sys_clk);
    if (isTrip) begin
      tripIn <= 1'b1;
    end else begin
      startIn <= 1'b1;
    end
    @(posedge sys_clk);
    @(posedge sys_clk);
    tripIn <= 1'b0;
    startIn <= 1'b0;
  endtask
endmodule

// file: verification/tvr_recorder_assertions.sv
// port checker of the trip value recorder
module tvr_recorder_chk
  import tvr_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // protection side
  input wire logic startIn,
  input wire logic tripIn,
  // event side
  input wire tvr_pkg::tvr_event_t evtRec,
  input wire logic evtValid,
  input wire logic armed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // report framing
  property p_trip_report;
    armed && $rose(tripIn) |-> ##2 evtValid [*6] ##1 !evtValid;
  endproperty
  a_trip_report: assert property (p_trip_report) else $error("no report");
  property p_rec_order;
    $rose(evtValid) |-> evtRec.chan == 2'h0 && !evtRec.isFault
      ##5 evtRec.chan == 2'h2 && evtRec.isFault;
  endproperty
  a_rec_order: assert property (p_rec_order) else $error("bad order");
  property p_idle_out;
    evtValid |-> !armed;
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("armed in report");
  property p_report_gap;
    $fell(evtValid) |-> !evtValid [*8];
  endproperty
  a_report_gap: assert property (p_report_gap) else $error("extra report");
  property p_rec_hold;
    !evtValid |-> $stable(evtRec);
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("record moved");
  property p_start_disarms;
    $rose(startIn) |=> !armed [*8];
  endproperty
  a_start_disarms: assert property (p_start_disarms) else $error("armed early");
  property p_disarm_cause;
    $fell(armed) |-> $past(tripIn) || $past(startIn);
  endproperty
  a_disarm_cause: assert property (p_disarm_cause) else $error("lost capture");
  c_armed: cover property ($rose(armed));
  c_report: cover property ($rose(evtValid));
  c_restart: cover property (armed && $rose(startIn));
  // report that never passed through the armed wait
  c_early: cover property ($rose(evtValid) && !$past(armed, 3));
endmodule
bind tvr_recorder tvr_recorder_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) uChk (
  .sys_clk(sys_clk), .rst_n(rst_n), .startIn(startIn), .tripIn(tripIn),
  .evtRec(evtRec), .evtValid(evtValid), .armed(armed));

// file: verification/tvr_recorder_bench.sv
// self-checking bench of the trip value recorder
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %h got %h", nm, e, g); miscompares++; end end
module tvr_recorder_bench;
  import tvr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic startIn, tripIn, evtValid, armed;
  tvr_mag3_t secMag = '0;
  tvr_ratio3_t ratio = {16'h0007, 16'h0005, 16'h0003};
  tvr_event_t evtRec;
  int miscompares = 0;
  int testsRun = 0;
  int cyc = 0;
  always #25 sys_clk = ~sys_clk;
  tvr_prot_model prot (.sys_clk(sys_clk), .startIn(startIn), .tripIn(tripIn));
  tvr_recorder #(.SAMPLE_CYCLES(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .startIn(startIn), .tripIn(tripIn), .secMag(secMag), .ratio(ratio),
    .evtValid(evtValid), .evtRec(evtRec), .armed(armed));
  task automatic endSim;
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    // whole run is about 2200 cycles
    if (cyc == 6000) begin
      miscompares++;
      endSim();
    end
  end
  // ==========================================
  // shared steps
  task automatic capture(input tvr_mag3_t p, a, b);
    // inputs only ever move on a rising edge
    @(posedge sys_clk);
    secMag <= p;
    repeat (450) @(posedge sys_clk);
    prot.pulse(1'b0);
    secMag <= a;
    repeat (60) @(posedge sys_clk);
    secMag <= b;
    repeat (30) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("armed", 1'b1, armed)
  endtask
  task automatic report(input tvr_mag3_t p, a, b, input bit doTrip);
    tvr_event_t exp;
    logic [32:0] sum;
    int n;
    n = 0;
    if (doTrip) begin
      prot.pulse(1'b1);
    end
    while (evtValid !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    for (int i = 0; i < 6; i++) begin
      exp.isFault = (i > 2);
      exp.chan = 2'(i % 3);
      sum = p.ch[i%3] * ratio.ch[i%3];
      if (i > 2) sum = (a.ch[i%3] * ratio.ch[i%3] + 33'(b.ch[i%3] * ratio.ch[i%3])) >> 1;
      exp.value = sum[31:0];
      `CHK("record", exp, evtRec)
      `CHK("valid", 1'b1, evtValid)
      @(negedge sys_clk);
    end
    `CHK("valid end", 1'b0, evtValid)
  endtask
  // ==========================================
  // scenarios
  task automatic tBasic;
    capture({16'h0100, 16'h0200, 16'h0300}, {16'h1111, 16'h2222, 16'hFFFF},
      {16'h1000, 16'h2001, 16'hFFFE});
    report({16'h0100, 16'h0200, 16'h0300}, {16'h1111, 16'h2222, 16'hFFFF},
      {16'h1000, 16'h2001, 16'hFFFE}, 1'b1);
    $display("basic done");
  endtask
  task automatic tRestart;
    capture({16'h0005, 16'h0006, 16'h0007}, {16'h0A00, 16'h0B00, 16'h0C00}, '0);
    capture({16'h0040, 16'h0050, 16'h0060}, {16'h0003, 16'h0004, 16'h0005},
      {16'h0008, 16'h0009, 16'h000A});
    report({16'h0040, 16'h0050, 16'h0060}, {16'h0003, 16'h0004, 16'h0005},
      {16'h0008, 16'h0009, 16'h000A}, 1'b1);
    $display("restart done");
  endtask
  // trip lands inside the fault window: report follows the 20 ms sample
  task automatic tEarlyTrip;
    @(posedge sys_clk);
    secMag <= {16'h0011, 16'h0022, 16'h0033};
    repeat (450) @(posedge sys_clk);
    prot.pulse(1'b0);
    secMag <= {16'h0123, 16'h0456, 16'h0789};
    repeat (20) @(posedge sys_clk);
    prot.pulse(1'b1);
    repeat (37) @(posedge sys_clk);
    secMag <= {16'h0321, 16'h0654, 16'h0987};
    repeat (15) begin
      @(negedge sys_clk);
      `CHK("early armed", 1'b0, armed)
    end
    report({16'h0011, 16'h0022, 16'h0033}, {16'h0123, 16'h0456, 16'h0789},
      {16'h0321, 16'h0654, 16'h0987}, 1'b0);
    $display("early trip done");
  endtask
  task automatic tIdleTrip;
    prot.pulse(1'b1);
    repeat (20) begin
      @(negedge sys_clk);
      `CHK("idle valid", 1'b0, evtValid)
    end
    $display("idle trip done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    tBasic();
    tRestart();
    tIdleTrip();
    tEarlyTrip();
    endSim();
  end
endmodule
